// File: logic/i2tl_accum.sv
// Energy accumulator, updated once per current sample.
// Assumes squared inputs are stable in the cycle that upd_i is high.
`timescale 1ns/100ps
module i2tl_accum #(
  parameter int SW = 32,
  parameter int AW = 48
) (
  // Clock, reset and enable
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  // Sample update
  input  wire logic          upd_i,
  input  wire logic [SW-1:0] meas_sq_i,
  input  wire logic [SW-1:0] cont_sq_i,
  // Result
  output logic      [AW-1:0] acc_o,
  output logic               done_o
);

  logic signed [SW:0]   inc;
  logic signed [AW+1:0] sum;

  if (AW < SW + 1) begin : g_chk
    $error("i2tl_accum: AW must exceed SW");
  end

  // --------------------------------------------------------------------
  // Signed step and new sum
  // --------------------------------------------------------------------
  // square minus continuous square
  assign inc = $signed({1'b0, meas_sq_i}) - $signed({1'b0, cont_sq_i});
  assign sum = $signed({2'b00, acc_o})
             + $signed({{(AW + 1 - SW){inc[SW]}}, inc});

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc_o <= '0;
    end
    else if (ce_i && upd_i)
    begin
      if (sum < 0)
        acc_o <= '0;
      else if (sum[AW])
        acc_o <= '1;
      else
        acc_o <= sum[AW-1:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      done_o <= 1'b0;
    else if (ce_i)
      done_o <= upd_i;
  end

endmodule : i2tl_accum

// File: logic/i2tl_map.svh
// Register offsets, field positions and reset values of the limiter.
// Assumes a 32-bit Wishbone slave with byte addresses in wb_adr_i.
`ifndef I2TL_MAP_SVH
`define I2TL_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define I2TL_ADR_W        8
`define I2TL_OFF_CTRL     8'h00
`define I2TL_OFF_PEAK     8'h04
`define I2TL_OFF_CONT     8'h08
`define I2TL_OFF_TIME     8'h0c
`define I2TL_OFF_SETPT_LO 8'h10
`define I2TL_OFF_SETPT_HI 8'h14
`define I2TL_OFF_ACC_LO   8'h18
`define I2TL_OFF_ACC_HI   8'h1c
`define I2TL_OFF_STATUS   8'h20
`define I2TL_OFF_MASK     8'h24
`define I2TL_OFF_STATE    8'h28

// ----------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------
`define I2TL_CTRL_FMODE   0
`define I2TL_CTRL_FCLR    1
`define I2TL_EVT_W        3
`define I2TL_HI_SHIFT     32

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define I2TL_RST_PEAK     32'hffffffff
`define I2TL_RST_CONT     32'hffffffff
`define I2TL_RST_TIME     32'h00000001
`define I2TL_RST_MASK     3'h0

`endif

// File: logic/i2tl_pkg.sv
// Types shared by the limiter modules.
// Assumes the map header is compiled alongside.
package i2tl_pkg;

  // --------------------------------------------------------------------
  // Limiter states
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    I2TL_NORMAL,
    I2TL_CLAMP,
    I2TL_FAULT
  } i2tl_state_e;

  // --------------------------------------------------------------------
  // Sticky event bits, same layout in status and mask
  // --------------------------------------------------------------------
  typedef struct packed {
    logic fault;
    logic lim_off;
    logic lim_on;
  } i2tl_evt_s;

  // --------------------------------------------------------------------
  // Live state word
  // --------------------------------------------------------------------
  typedef struct packed {
    logic over;
    logic fault;
    logic active;
  } i2tl_live_s;

endpackage : i2tl_pkg

// File: logic/i2tl_top.sv
// I2T current limiter: energy accumulator, setpoint, clamp or fault.
// Assumes a classic Wishbone master, a one-cycle sample strobe from the
// current loop and a signed current command synchronous to clk_i.
//
// Notes on behaviour
// - The setpoint is the squared peak limit minus the squared continuous limit, times the time limit.
// - The accumulator is refreshed once for each current sample.
// - Each refresh adds the squared sample minus the squared continuous limit, times one sample period.
// - The accumulator rises above the continuous limit and falls below it.
// - The accumulator never goes below zero.
// - Reset clears the accumulator to zero.
// - After each refresh the accumulator is tested strictly greater than the setpoint.
// - Exceeding the setpoint starts current limiting to the continuous limit.
// - While limiting, a command above the continuous limit gives exactly that limit.
// - While limiting, a command at or below the limit passes unchanged.
// - Software selects limiting or fault as the response.
// - In fault mode an overrun latches a fault until it is cleared.
`timescale 1ns/100ps
`include "i2tl_map.svh"
module i2tl_top
  import i2tl_pkg::*;
#(
  parameter int CW = 16,
  parameter int TW = 16
) (
  // Clock, reset and enable
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  // Wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [`I2TL_ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // Current loop
  input  wire logic                    smp_valid_i,
  input  wire logic [CW-1:0]           smp_meas_i,
  input  wire logic signed [CW-1:0]    cmd_i,
  output logic signed [CW-1:0]         cur_o,
  // Status
  output logic                         limit_o,
  output logic                         fault_o,
  output logic                         irq_o
);

  localparam int SW = 2 * CW;
  localparam int AW = SW + TW;

  if (CW < 2 || CW > 32 || TW < 1 || AW <= 32 || AW > 64) begin : g_chk
    $error("i2tl_top: CW and TW give an unusable accumulator width");
  end

  // --------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------
  function automatic logic [SW-1:0] sq(input logic [CW-1:0] v);
    sq = SW'(v) * SW'(v);
  endfunction : sq

  function automatic logic [31:0] wmask(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    wmask = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        wmask[8*b +: 8] = nw[8*b +: 8];
  endfunction : wmask

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  logic [CW-1:0] peak_reg;
  logic [CW-1:0] cont_reg;
  logic [TW-1:0] time_reg;
  logic          fmode_reg;
  i2tl_evt_s     mask_reg;
  i2tl_evt_s     stat_reg;
  i2tl_evt_s     stat_next;
  i2tl_evt_s     evt;
  i2tl_evt_s     w1c;
  i2tl_live_s    live;
  i2tl_state_e   st_reg;
  i2tl_state_e   st_next;
  logic [AW-1:0] setpt_reg;
  logic [SW-1:0] diff;
  logic [AW-1:0] acc;
  logic          done;
  logic          over;
  logic          over_reg;
  logic          wr;
  logic          rd;
  logic          fclr;
  logic [CW-1:0] mag;

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      peak_reg  <= CW'(`I2TL_RST_PEAK);
      cont_reg  <= CW'(`I2TL_RST_CONT);
      time_reg  <= TW'(`I2TL_RST_TIME);
      fmode_reg <= 1'b0;
      mask_reg  <= `I2TL_RST_MASK;
    end
    else if (ce_i && wr)
    begin
      case (wb_adr_i)
        `I2TL_OFF_CTRL:
          if (wb_sel_i[0])
            fmode_reg <= wb_dat_i[`I2TL_CTRL_FMODE];
        `I2TL_OFF_PEAK:
          peak_reg <= CW'(wmask(32'(peak_reg), wb_dat_i, wb_sel_i));
        `I2TL_OFF_CONT:
          cont_reg <= CW'(wmask(32'(cont_reg), wb_dat_i, wb_sel_i));
        `I2TL_OFF_TIME:
          time_reg <= TW'(wmask(32'(time_reg), wb_dat_i, wb_sel_i));
        `I2TL_OFF_MASK:
          if (wb_sel_i[0])
            mask_reg <= wb_dat_i[`I2TL_EVT_W-1:0];
        default:
          ;
      endcase
    end
  end

  assign fclr = wr && wb_adr_i == `I2TL_OFF_CTRL && wb_sel_i[0]
             && wb_dat_i[`I2TL_CTRL_FCLR];
  assign w1c  = (wr && wb_adr_i == `I2TL_OFF_STATUS && wb_sel_i[0])
              ? wb_dat_i[`I2TL_EVT_W-1:0] : '0;

  // --------------------------------------------------------------------
  // Setpoint
  // --------------------------------------------------------------------
  // difference of squares times time, zero when cont is not below peak
  assign diff = (sq(peak_reg) > sq(cont_reg))
              ? sq(peak_reg) - sq(cont_reg) : '0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      setpt_reg <= '0;
    else if (ce_i)
      setpt_reg <= AW'(diff) * AW'(time_reg);
  end

  // --------------------------------------------------------------------
  // Accumulator
  // --------------------------------------------------------------------
  i2tl_accum #(
    .SW (SW),
    .AW (AW)
  ) u_accum (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .upd_i     (smp_valid_i),
    .meas_sq_i (sq(smp_meas_i)),
    .cont_sq_i (sq(cont_reg)),
    .acc_o     (acc),
    .done_o    (done)
  );

  assign over = acc > setpt_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      over_reg <= 1'b0;
    else if (ce_i && done)
      over_reg <= over;
  end

  // --------------------------------------------------------------------
  // Limiter state machine
  // --------------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    unique case (st_reg)
      I2TL_NORMAL:
        if (done && over)
          st_next = fmode_reg ? I2TL_FAULT : I2TL_CLAMP;
      I2TL_CLAMP:
        if (fmode_reg || (done && !over))
          st_next = I2TL_NORMAL;
      I2TL_FAULT:
        if (fclr)
          st_next = I2TL_NORMAL;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_reg <= I2TL_NORMAL;
    else if (ce_i)
      st_reg <= st_next;
  end

  assign evt.lim_on  = st_reg != I2TL_CLAMP && st_next == I2TL_CLAMP;
  assign evt.lim_off = st_reg == I2TL_CLAMP && st_next != I2TL_CLAMP;
  assign evt.fault   = st_reg != I2TL_FAULT && st_next == I2TL_FAULT;

  // --------------------------------------------------------------------
  // Interrupt status
  // --------------------------------------------------------------------
  // An event in the clearing cycle stays set.
  assign stat_next = (stat_reg & ~w1c) | evt;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stat_reg <= '0;
      irq_o    <= 1'b0;
    end
    else if (ce_i)
    begin
      stat_reg <= stat_next;
      irq_o    <= |(stat_next & mask_reg);
    end
  end

  // --------------------------------------------------------------------
  // Current output
  // --------------------------------------------------------------------
  assign mag = cmd_i[CW-1] ? CW'(-cmd_i) : cmd_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cur_o   <= '0;
      limit_o <= 1'b0;
      fault_o <= 1'b0;
    end
    else if (ce_i)
    begin
      limit_o <= st_next == I2TL_CLAMP;
      fault_o <= st_next == I2TL_FAULT;
      if (st_reg == I2TL_FAULT)
        cur_o <= '0;
      else if (st_reg == I2TL_CLAMP && mag > cont_reg)
        cur_o <= cmd_i[CW-1] ? -$signed(cont_reg) : $signed(cont_reg);
      else
        cur_o <= cmd_i;
    end
  end

  // --------------------------------------------------------------------
  // Wishbone read and acknowledge
  // --------------------------------------------------------------------
  assign live.over   = over_reg;
  assign live.fault  = st_reg == I2TL_FAULT;
  assign live.active = st_reg == I2TL_CLAMP;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else if (ce_i)
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= '0;
    else if (ce_i && rd)
    begin
      case (wb_adr_i)
        `I2TL_OFF_CTRL:     wb_dat_o <= 32'(fmode_reg);
        `I2TL_OFF_PEAK:     wb_dat_o <= 32'(peak_reg);
        `I2TL_OFF_CONT:     wb_dat_o <= 32'(cont_reg);
        `I2TL_OFF_TIME:     wb_dat_o <= 32'(time_reg);
        `I2TL_OFF_SETPT_LO: wb_dat_o <= setpt_reg[31:0];
        `I2TL_OFF_SETPT_HI:
          wb_dat_o <= 32'(setpt_reg >> `I2TL_HI_SHIFT);
        `I2TL_OFF_ACC_LO:   wb_dat_o <= acc[31:0];
        `I2TL_OFF_ACC_HI:
          wb_dat_o <= 32'(acc >> `I2TL_HI_SHIFT);
        `I2TL_OFF_STATUS:   wb_dat_o <= 32'(stat_reg);
        `I2TL_OFF_MASK:     wb_dat_o <= 32'(mask_reg);
        `I2TL_OFF_STATE:    wb_dat_o <= 32'(live);
        default:            wb_dat_o <= '0;
      endcase
    end
  end

endmodule : i2tl_top

// File: tb/i2tl_checker.sv
// Port-level assertions for the limiter top.
// Assumes ce_i is high whenever reset is asserted.
`timescale 1ns/100ps
module i2tl_checker #(
  parameter int CW = 16
) (
  // Clock and reset
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 ce_i,
  // Bus handshake
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_ack_o,
  // Current loop and status
  input wire logic                 smp_valid_i,
  input wire logic signed [CW-1:0] cmd_i,
  input wire logic signed [CW-1:0] cur_o,
  input wire logic                 limit_o,
  input wire logic                 fault_o,
  input wire logic                 irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking

  a_ack_answer: assert property (disable iff (rst_i)
    ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_reset_clears: assert property (
    rst_i && ce_i |=> !limit_o && !fault_o && !irq_o && cur_o == 0)
    else $error("outputs not cleared by reset");
  a_pass_normal: assert property (disable iff (rst_i)
    !limit_o && !fault_o |=> cur_o == $past(cmd_i))
    else $error("command not passed while not limiting");
  a_clamp_bound: assert property (disable iff (rst_i)
    limit_o && !fault_o && cmd_i >= 0
    |=> cur_o >= 0 && cur_o <= $past(cmd_i))
    else $error("clamped output outside command range");
  a_fault_zero: assert property (disable iff (rst_i)
    fault_o |=> cur_o == 0)
    else $error("output not zero while faulted");
  a_mode_excl: assert property (disable iff (rst_i)
    !(limit_o && fault_o))
    else $error("limit and fault at once");
  a_limit_cause: assert property (disable iff (rst_i)
    $rose(limit_o) |-> $past(smp_valid_i, 2))
    else $error("limiting began without a sample");
  a_fault_cause: assert property (disable iff (rst_i)
    $rose(fault_o) |-> $past(smp_valid_i, 2))
    else $error("fault began without a sample");
  a_ce_freeze: assert property (disable iff (rst_i)
    !ce_i |=> $stable(cur_o) && $stable(limit_o) && $stable(fault_o)
      && $stable(irq_o) && $stable(wb_ack_o))
    else $error("outputs moved while the clock enable was low");
endmodule : i2tl_checker

bind i2tl_top i2tl_checker #(.CW(CW)) u_chk (.clk_i, .rst_i, .ce_i,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .smp_valid_i, .cmd_i, .cur_o,
  .limit_o, .fault_o, .irq_o);

// File: tb/i2tl_loop_model.sv
// Stand-in for the current loop: one measured sample per request.
// Assumes requests are single-cycle and spaced by the bench.
`timescale 1ns/100ps
module i2tl_loop_model (
  // Clock and request
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic        lag_i,
  input  wire logic [15:0] amp_i,
  // Sample to the limiter
  output logic             smp_valid_o,
  output logic      [15:0] smp_meas_o
);
  logic        req_reg;
  logic [15:0] amp_reg;
  logic        go;
  logic [15:0] val;

  assign go  = lag_i ? req_reg : req_i;
  assign val = lag_i ? amp_reg : amp_i;

  always_ff @(posedge clk_i)
  begin
    req_reg <= req_i;
    amp_reg <= amp_i;
  end

  // Outside strobes the line toggles, so stale data is never trusted.
  always_ff @(posedge clk_i)
  begin
    smp_valid_o <= go;
    smp_meas_o  <= go ? val : ~smp_meas_o;
  end
endmodule : i2tl_loop_model

// File: tb/test_i2t_current_limiter.sv
// Self-checking bench for the I2T limiter.
// Assumes the limiter, checker and loop stand-in are compiled first.
`timescale 1ns/100ps
`include "i2tl_map.svh"
module test_i2t_current_limiter;
  localparam int C = 6;
  localparam int P = 12;
  localparam int SP = P * P - C * C;
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               ce_i = 1'b1;
  logic               cyc = 1'b0;
  logic               stb = 1'b0;
  logic               we = 1'b0;
  logic [7:0]         adr = 8'h00;
  logic [31:0]        wdat = 32'h0;
  logic [31:0]        rdat;
  logic               req = 1'b0;
  logic               lag = 1'b0;
  logic [15:0]        amp = 16'h0;
  logic signed [15:0] cmd = 16'sh0;
  logic signed [15:0] tc [5] = '{12, -12, 6, 5, -3};
  wire  [31:0]        dat_o;
  wire                ack, smpv, lim, flt, irq;
  wire  [15:0]        smpm;
  wire  signed [15:0] cur;
  int                 fails = 0;
  int                 cmp_count = 0;
  int                 seed = 75638;
  int                 mr;
  longint             eacc = 0;

  always #50 clk_i = ~clk_i;

  i2tl_top #(.CW(16), .TW(16)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .smp_valid_i(smpv), .smp_meas_i(smpm), .cmd_i(cmd), .cur_o(cur),
    .limit_o(lim), .fault_o(flt), .irq_o(irq));

  i2tl_loop_model i_loop (.clk_i(clk_i), .req_i(req), .lag_i(lag),
    .amp_i(amp), .smp_valid_o(smpv), .smp_meas_o(smpm));

  function automatic longint nxt(longint a, longint m);
    longint t;
    t = a + m * m - C * C;
    return (t < 0) ? 0 : t;
  endfunction : nxt

  function automatic logic signed [15:0] clampf(logic signed [15:0] c);
    if (c > C)
      return 16'sd6;
    if (c < -C)
      return -16'sd6;
    return c;
  endfunction : clampf

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string n, input logic [47:0] e,
                     input logic [47:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %0h seen %0h", n, e, g);
      fails++;
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20)
    begin
      fails++;
      wrap_up();
    end
  endtask : wb

  task automatic rd(input string n, input logic [7:0] a,
                    input logic [47:0] e);
    wb(1'b0, a, 32'h0);
    chk(n, e, {16'h0, rdat});
  endtask : rd

  task automatic smp(input logic [15:0] m);
    @(posedge clk_i);
    req <= 1'b1;
    amp <= m;
    @(posedge clk_i);
    req <= 1'b0;
    repeat (6) @(posedge clk_i);
    eacc = nxt(eacc, m);
  endtask : smp

  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("peak", `I2TL_OFF_PEAK, 48'hffff);
    rd("time", `I2TL_OFF_TIME, 48'h1);
    rd("mask", `I2TL_OFF_MASK, 48'h0);
    rd("setpt", `I2TL_OFF_SETPT_LO, 48'h0);
    rd("acc", `I2TL_OFF_ACC_LO, 48'h0);
    wb(1'b1, 8'h3c, 32'h5);
    rd("unmapped", 8'h3c, 48'h0);
    $display("test defaults done");
    wb(1'b1, `I2TL_OFF_PEAK, 32'hc);
    wb(1'b1, `I2TL_OFF_CONT, 32'h6);
    wb(1'b1, `I2TL_OFF_TIME, 32'h1);
    rd("setpt", `I2TL_OFF_SETPT_LO, 48'h6c);
    wb(1'b1, `I2TL_OFF_MASK, 32'h1);
    smp(16'hc);
    rd("acc", `I2TL_OFF_ACC_LO, eacc);
    chk("limit", 48'h0, lim);
    smp(16'hc);
    chk("limit", 48'h1, lim);
    chk("irq", 48'h1, irq);
    for (int i = 0; i < 5; i++)
    begin
      cmd <= tc[i];
      repeat (2) @(posedge clk_i);
      chk("cur", clampf(tc[i]), cur);
    end
    wb(1'b1, `I2TL_OFF_STATUS, 32'h1);
    @(posedge clk_i);
    chk("irq", 48'h0, irq);
    repeat (3) smp(16'h0);
    chk("limit", 48'h0, lim);
    chk("irq", 48'h0, irq);
    rd("status", `I2TL_OFF_STATUS, 48'h2);
    cmd <= 16'sd12;
    repeat (2) @(posedge clk_i);
    chk("cur", 48'hc, cur);
    repeat (4) smp(16'h0);
    rd("acc", `I2TL_OFF_ACC_LO, eacc);
    $display("test limiting done");
    wb(1'b1, `I2TL_OFF_CTRL, 32'h1);
    wb(1'b1, `I2TL_OFF_MASK, 32'h4);
    smp(16'hc);
    smp(16'hc);
    chk("fault", 48'h1, flt);
    chk("limit", 48'h0, lim);
    chk("cur", 48'h0, cur);
    chk("irq", 48'h1, irq);
    repeat (3) smp(16'h0);
    wb(1'b1, `I2TL_OFF_CTRL, 32'h3);
    repeat (2) @(posedge clk_i);
    chk("fault", 48'h0, flt);
    wb(1'b1, `I2TL_OFF_STATUS, 32'h7);
    wb(1'b1, `I2TL_OFF_CTRL, 32'h0);
    $display("test fault done");
    // A sample strobe while the enable is low must leave no trace.
    ce_i <= 1'b0;
    @(posedge clk_i);
    req <= 1'b1;
    amp <= 16'hc;
    @(posedge clk_i);
    req <= 1'b0;
    repeat (4) @(posedge clk_i);
    ce_i <= 1'b1;
    rd("acc", `I2TL_OFF_ACC_LO, eacc);
    $display("test enable done");
    for (int i = 0; i < 30; i++)
    begin
      mr = {$random(seed)} % 13;
      cmd <= 16'($random(seed));
      lag <= 1'($random(seed));
      smp(mr[15:0]);
      rd("acc", `I2TL_OFF_ACC_LO, eacc);
      chk("limit", eacc > SP, lim);
      chk("cur", (eacc > SP) ? clampf(cmd) : cmd, cur);
    end
    $display("test random done");
    smp(16'hc);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("limit", 48'h0, lim);
    rd("acc", `I2TL_OFF_ACC_LO, 48'h0);
    $display("test reset done");
    wrap_up();
  end
endmodule : test_i2t_current_limiter
